// File: core/sfmc_regs.svh
// Fixed-point thresholds and codes for the frame mode classifier
`ifndef SFMC_REGS_SVH
`define SFMC_REGS_SVH
// Correlation sums and single correlations, Q4.12 signed
`define SFMC_R068   17'sh0ae1
`define SFMC_R0695  17'sh0b1f
`define SFMC_R074   17'sh0bd7
`define SFMC_R079   17'sh0ca4
`define SFMC_R076   17'sh0c29
`define SFMC_R0605  16'sh09ae
`define SFMC_R095   16'sh0f33
`define SFMC_R097   16'sh0f85
// Spectral tilt, Q8.8 unsigned
`define SFMC_T62    16'h0633
`define SFMC_T24    16'h0266
`define SFMC_T10    16'h0a00
`define SFMC_T95    16'h0980
`define SFMC_T98    16'h09cd
`define SFMC_T40    16'h0400
// High-band energy 0.0035, Q0.16
`define SFMC_EH     16'h00e5
// Energy variation, Q16.8: 30, 29, 30 dB
`define SFMC_ED30   24'h001e00
`define SFMC_ED29   24'h001d00
`define SFMC_EDDB30 24'h03e800
// Decay ratio limits Q10.8: 21 dB, 30 dB
`define SFMC_DB21   18'h07de5
`define SFMC_DB30   18'h3e800
// 1e-5 in segment energy units (LSB 2^-16)
`define SFMC_EPS    17'h00001
// Frame energy difference 5, relative energy -13, Q8.8
`define SFMC_DET5   16'sh0500
`define SFMC_EREL13 (-16'sh0d00)
// Lag limits: fractional Q12.4 and integer
`define SFMC_LAG3   17'sh00030
`define SFMC_OL3    8'h03
// Decay search span and last start that fits
`define SFMC_SPAN   4'h9
`define SFMC_FIT    4'h6
// Hysteresis codes
`define SFMC_H_IDLE (-3'sh1)
`define SFMC_H_DET  3'sh0
`define SFMC_H_NEXT 3'sh1
`define SFMC_H_HOLD 3'sh2
`endif

// File: core/sfmc_pkg.sv
// Types shared by the frame mode classifier
package sfmc_pkg;
	typedef enum logic [1:0] {
		mode_generic, mode_unvoiced, mode_stable_voiced, mode_music
	} sfmc_mode_t;
	typedef enum logic [1:0] {bw_nb, bw_wb, bw_swb, bw_fb} sfmc_bw_t;
	typedef logic signed [2:0] sfmc_hyst_t;
	typedef logic [31:0][15:0] sfmc_seg2_t;
	typedef struct packed {
		sfmc_bw_t                 bw;
		logic signed [15:0]       rxy3;
		logic signed [15:0]       re;
		logic signed [15:0]       cn0;
		logic signed [15:0]       cn2;
		logic [15:0]              tilt0;
		logic [15:0]              tilt1;
		logic [15:0]              tilt_avg;
		logic [15:0]              eh0;
		logic [15:0]              eh1;
		logic [23:0]              ed;
		logic [2:0]               peak_j;
		logic                     peak_set;
		logic [15:0][15:0]        seg;
		logic signed [15:0]       det;
		logic signed [15:0]       erel;
		logic [3:0][15:0]         dfr;
		logic [3:0][15:0]         cfr;
		logic [3:0][7:0]          tol;
		logic signed [15:0]       voicing_m;
		logic signed [15:0]       smoothed_voicing;
		logic                     spitch;
	} sfmc_frame_t;
	typedef struct packed {
		sfmc_mode_t               mode;
		sfmc_mode_t               raw_mode_prev;
		sfmc_hyst_t               spike_hyst_state;
		logic                     spitch;
		logic signed [15:0]       corr_sm;
	} sfmc_result_t;
endpackage

// File: core/sfmc_classifier.sv
// Per-frame raw coding mode decision with spike-decay hysteresis
`timescale 1ns/100ps
`include "sfmc_regs.svh"
module sfmc_classifier (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 in_valid,
	input  wire sfmc_pkg::sfmc_frame_t fr,
	output logic                      out_valid,
	output sfmc_pkg::sfmc_result_t    res
);
	// Sum of two correlations compared below a limit
	function automatic logic lt_sum(
		input logic signed [15:0] a,
		input logic signed [15:0] b,
		input logic signed [16:0] th
	);
		lt_sum = (17'(a) + 17'(b)) < th;
	endfunction

	// Decay ratio test over ten consecutive segments
	function automatic logic decay_hit(
		input sfmc_pkg::sfmc_seg2_t a,
		input logic [4:0]           st,
		input logic                 nb
	);
		logic [15:0] mx;
		logic [15:0] mn;
		logic        up;
		logic [4:0]  ix;
		logic [17:0] thr;
		logic [39:0] lhs;
		logic [39:0] rhs;
		mx = a[st];
		mn = mx;
		up = 1'b1;
		for (int k = 1; k <= 9; k++) begin
			ix = st + 5'(k);
			// Follow the rise, then take the running minimum
			if (up && a[ix] > a[ix - 5'h01]) begin
				mx = a[ix];
				mn = a[ix];
			end else begin
				up = 1'b0;
				if (a[ix] < mn) begin
					mn = a[ix];
				end
			end
		end
		thr = nb ? `SFMC_DB21 : `SFMC_DB30;
		lhs = {16'h0000, mx, 8'h00};
		rhs = 40'(thr) * 40'({1'b0, mn} + `SFMC_EPS);
		decay_hit = lhs > rhs;
	endfunction

	// Registered state
	logic                       valid_q;
	sfmc_pkg::sfmc_mode_t       mode_q, mode_d;
	sfmc_pkg::sfmc_mode_t       prev_q, prev_d;
	sfmc_pkg::sfmc_hyst_t       hyst_q, hyst_d;
	logic                       spitch_q, spitch_d;
	logic signed [15:0]         sm_q, sm_d;
	logic [23:0]                edp_q, edp_d;
	logic [15:0][15:0]          segp_q, segp_d;
	logic                       pend_q, pend_d;
	logic [3:0]                 pst_q, pst_d;
	// Frame decision terms
	logic                       nb;
	logic                       trig;
	logic                       fits;
	logic [3:0]                 st;
	sfmc_pkg::sfmc_seg2_t       seg2;
	logic                       hit_now;
	logic                       hit_late;
	logic                       uv;
	logic                       smooth;
	logic                       cfr_ok;
	logic                       ol_ok;
	logic                       vc;
	logic signed [17:0]         csum;
	logic signed [15:0]         cmean;
	logic signed [17:0]         smx;

	// Spike detection, hysteresis and the mode decision
	always_comb begin
		nb = (fr.bw == sfmc_pkg::bw_nb);
		seg2 = {fr.seg, segp_q};
		st = {fr.peak_j, 1'b0} + {3'h0, fr.peak_set};
		fits = st <= `SFMC_FIT;
		// Variation trigger, narrowband also needs low correlation
		trig = fr.ed > `SFMC_EDDB30 &&
			(!nb || lt_sum(fr.rxy3, fr.re, `SFMC_R068));
		hit_now = trig && fits &&
			decay_hit(seg2, {1'b1, st}, nb);
		hit_late = pend_q &&
			decay_hit(seg2, {1'b0, pst_q}, nb);
		// Hysteresis walk
		if (hit_now) begin
			hyst_d = `SFMC_H_DET;
		end else if (hit_late) begin
			hyst_d = `SFMC_H_NEXT;
		end else if (hyst_q == `SFMC_H_DET) begin
			hyst_d = `SFMC_H_NEXT;
		end else if (hyst_q == `SFMC_H_NEXT) begin
			hyst_d = `SFMC_H_HOLD;
		end else if (hyst_q == `SFMC_H_HOLD &&
			(fr.det > `SFMC_DET5 || (fr.erel > `SFMC_EREL13 &&
			lt_sum(fr.rxy3, fr.re, `SFMC_R0695)))) begin
			hyst_d = `SFMC_H_IDLE;
		end else begin
			hyst_d = hyst_q;
		end
		// Unvoiced test
		if (nb) begin
			uv = lt_sum(fr.rxy3, fr.re, `SFMC_R068) &&
				lt_sum(fr.cn2, fr.re, `SFMC_R079) &&
				fr.tilt0 < `SFMC_T10 && fr.tilt1 < `SFMC_T95 &&
				fr.eh0 > `SFMC_EH && fr.eh1 > `SFMC_EH &&
				// Last decided mode is the previous frame's raw mode
				(mode_q == sfmc_pkg::mode_unvoiced ||
				(fr.tilt0 < `SFMC_T98 && fr.eh0 > `SFMC_EH &&
				lt_sum(fr.cn0, fr.re, `SFMC_R076))) &&
				fr.ed <= `SFMC_ED29 &&
				edp_q <= `SFMC_ED29;
		end else begin
			uv = lt_sum(fr.rxy3, fr.re, `SFMC_R0695) &&
				fr.tilt0 < `SFMC_T62 && fr.tilt1 < `SFMC_T62 &&
				fr.eh0 > `SFMC_EH && fr.eh1 > `SFMC_EH &&
				(mode_q == sfmc_pkg::mode_unvoiced ||
				(fr.tilt0 < `SFMC_T24 && fr.eh0 > `SFMC_EH &&
				lt_sum(fr.cn0, fr.re, `SFMC_R074))) &&
				fr.ed <= `SFMC_ED30 &&
				edp_q <= `SFMC_ED30;
		end
		uv = uv && hyst_d[2];
		// Pitch smoothness and correlation terms
		smooth = 1'b1;
		cfr_ok = 1'b1;
		ol_ok = 1'b1;
		csum = 18'sh00000;
		for (int i = 0; i < 3; i++) begin
			if ((17'($signed({1'b0, fr.dfr[i + 1]})) -
				17'($signed({1'b0, fr.dfr[i]}))) >= `SFMC_LAG3) begin
				smooth = 1'b0;
			end
			if ((fr.tol[i] > fr.tol[i + 1] ?
				fr.tol[i] - fr.tol[i + 1] :
				fr.tol[i + 1] - fr.tol[i]) > `SFMC_OL3) begin
				ol_ok = 1'b0;
			end
		end
		for (int i = 0; i < 4; i++) begin
			if ($signed(fr.cfr[i]) <= `SFMC_R0605) begin
				cfr_ok = 1'b0;
			end
			csum = csum + 18'($signed(fr.cfr[i]));
		end
		cmean = 16'(csum >>> 2);
		smx = 18'(sm_q) + 18'(sm_q) + 18'(sm_q) + 18'(cmean);
		sm_d = 16'(smx >>> 2);
		vc = (smooth && cfr_ok && fr.tilt_avg > `SFMC_T40) ||
			(smooth && cmean > `SFMC_R095 &&
			sm_d > `SFMC_R097);
		// Short-pitch flag
		spitch_d = fr.spitch || (ol_ok &&
			fr.voicing_m > `SFMC_R095 &&
			fr.smoothed_voicing > `SFMC_R097);
		// Decision order
		mode_d = sfmc_pkg::mode_generic;
		if (uv) begin
			mode_d = sfmc_pkg::mode_unvoiced;
		end else if (vc || spitch_d) begin
			mode_d = sfmc_pkg::mode_stable_voiced;
		end
		spitch_d = spitch_d && !uv;
		prev_d = mode_q;
		edp_d = fr.ed;
		segp_d = fr.seg;
		pend_d = trig && !fits;
		pst_d = st;
	end

	// Frame state updates once per strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			valid_q  <= 1'b0;
			mode_q   <= sfmc_pkg::mode_generic;
			prev_q   <= sfmc_pkg::mode_generic;
			hyst_q   <= `SFMC_H_IDLE;
			spitch_q <= 1'b0;
			sm_q     <= 16'sh0000;
			edp_q    <= 24'h000000;
			segp_q   <= '0;
			pend_q   <= 1'b0;
			pst_q    <= 4'h0;
		end else begin
			valid_q <= in_valid;
			if (in_valid) begin
				mode_q   <= mode_d;
				prev_q   <= prev_d;
				hyst_q   <= hyst_d;
				spitch_q <= spitch_d;
				sm_q     <= sm_d;
				edp_q    <= edp_d;
				segp_q   <= segp_d;
				pend_q   <= pend_d;
				pst_q    <= pst_d;
			end
		end
	end

	// Result outputs
	assign out_valid = valid_q;
	assign res = '{mode: mode_q, raw_mode_prev: prev_q,
		spike_hyst_state: hyst_q, spitch: spitch_q, corr_sm: sm_q};

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Strobe answers once; the result holds between frames
	property p_one_out;
		(in_valid |=> out_valid) and
			(!in_valid |=> !out_valid && $stable(res));
	endproperty
	a_one_out: assert property (p_one_out)
		else $error("decision strobe or result out of step");

	property p_uv_idle;
		out_valid && mode_q == sfmc_pkg::mode_unvoiced
			|-> hyst_q < 3'sh0;
	endproperty
	a_uv_idle: assert property (p_uv_idle)
		else $error("unvoiced outside idle hysteresis");

	property p_det;
		in_valid && hit_now |=> hyst_q == `SFMC_H_DET &&
			mode_q != sfmc_pkg::mode_unvoiced;
	endproperty
	a_det: assert property (p_det)
		else $error("detection not in state 0");

	property p_step;
		in_valid && hyst_q == `SFMC_H_DET && !hit_now
			|=> hyst_q == `SFMC_H_NEXT;
	endproperty
	a_step: assert property (p_step)
		else $error("state 0 did not step to 1");

	property p_idle;
		in_valid && hyst_q == `SFMC_H_IDLE && !hit_now && !hit_late
			|=> hyst_q == `SFMC_H_IDLE;
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle hysteresis left without detection");

	property p_late;
		in_valid && hit_late && !hit_now |=> hyst_q == `SFMC_H_NEXT;
	endproperty
	a_late: assert property (p_late)
		else $error("late detection not one frame old");

	property p_prev;
		in_valid |=> prev_q == $past(mode_q);
	endproperty
	a_prev: assert property (p_prev)
		else $error("previous raw mode not kept");

	property p_spitch;
		in_valid && fr.spitch && !uv |=>
			mode_q == sfmc_pkg::mode_stable_voiced && spitch_q;
	endproperty
	a_spitch: assert property (p_spitch)
		else $error("short-pitch flag did not force voiced");

	property p_edlim;
		in_valid && fr.ed > `SFMC_ED30 |=>
			mode_q != sfmc_pkg::mode_unvoiced;
	endproperty
	a_edlim: assert property (p_edlim)
		else $error("unvoiced despite energy jump");

	c_uv: cover property (out_valid &&
		mode_q == sfmc_pkg::mode_unvoiced);
	c_vc: cover property (out_valid &&
		mode_q == sfmc_pkg::mode_stable_voiced);
	c_late: cover property (in_valid && hit_late);
endmodule

// File: verif/sfmc_src.sv
// Upstream parameter source model, one frame per strobe
`timescale 1ns/100ps
module sfmc_src (
	input  wire logic             clk,
	output sfmc_pkg::sfmc_frame_t fr,
	output logic                  in_valid
);
	// Idle at time zero
	initial begin
		in_valid = 1'b0;
		fr = '0;
	end
	// Frame held for the strobe cycle only, then scrambled
	task automatic put(input sfmc_pkg::sfmc_frame_t f);
		@(posedge clk);
		in_valid <= 1'b1;
		fr <= f;
		@(posedge clk);
		in_valid <= 1'b0;
		fr <= ~f;
	endtask
endmodule

// File: verif/tb.sv
// Self-checking bench for the frame mode classifier
`timescale 1ns/100ps
module tb;
	typedef sfmc_pkg::sfmc_frame_t fr_t;
	localparam sfmc_pkg::sfmc_mode_t gn  = sfmc_pkg::mode_generic;
	localparam sfmc_pkg::sfmc_mode_t uv  = sfmc_pkg::mode_unvoiced;
	localparam sfmc_pkg::sfmc_mode_t vc  = sfmc_pkg::mode_stable_voiced;
	localparam sfmc_pkg::sfmc_hyst_t idl = 3'h7;
	logic                   clk;         // 200 MHz clock
	logic                   rst;         // Async reset
	logic                   in_valid;    // Frame strobe
	fr_t                    fr;          // Frame fields
	logic                   out_valid;   // Decision strobe
	sfmc_pkg::sfmc_result_t res;         // Decision
	int                     mismatches;  // Failed compares
	int                     cmp_count;   // All compares
	int                     cycles;      // Watchdog count
	int                     csm;         // Expected smoothed corr
	sfmc_pkg::sfmc_mode_t   pm;          // Expected previous mode
	sfmc_classifier u_sfmc_classifier (
		.clk(clk), .rst(rst), .in_valid(in_valid), .fr(fr),
		.out_valid(out_valid), .res(res));
	sfmc_src u_sfmc_src (.clk(clk), .fr(fr), .in_valid(in_valid));
	// Clock
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	// Watchdog
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			test_done();
		end
	end
	// Compare and report
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("Error %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic test_done();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Frame that passes every unvoiced test and no voiced test
	function automatic fr_t quiet(input sfmc_pkg::sfmc_bw_t b);
		fr_t f;
		f = '0;
		f.bw = b;
		f.tilt0 = 16'h0100;
		f.tilt1 = 16'h0100;
		f.tilt_avg = 16'h0100;
		f.eh0 = 16'h1000;
		f.eh1 = 16'h1000;
		f.ed = 24'h000100;
		f.erel = -16'sh2000;
		f.tol = {8'h3c, 8'h28, 8'h14, 8'h00};
		return f;
	endfunction
	// Send one frame and judge the decision that follows
	task automatic go(input fr_t f, input sfmc_pkg::sfmc_mode_t m,
		input sfmc_pkg::sfmc_hyst_t h);
		int s;
		s = $signed(f.cfr[0]) + $signed(f.cfr[1]);
		s = (s + $signed(f.cfr[2]) + $signed(f.cfr[3])) >>> 2;
		csm = (3 * csm + s) >>> 2;
		u_sfmc_src.put(f);
		#1;
		chk(out_valid, 1'b1);
		chk(res.mode, m);
		chk(res.raw_mode_prev, pm);
		chk(res.spike_hyst_state, h);
		chk(res.corr_sm, csm[15:0]);
		pm = m;
		@(posedge clk);
		#1;
		chk(out_valid, 1'b0);
	endtask
	// Reset and check cleared state
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		csm = 0;
		pm = gn;
		chk(out_valid, 1'b0);
		chk(res.mode, gn);
		chk(res.spike_hyst_state, idl);
		chk({res.spitch, res.corr_sm}, 0);
	endtask
	// Wideband unvoiced limits
	task automatic t_wb();
		fr_t f;
		f = quiet(sfmc_pkg::bw_wb);
		go(f, uv, idl);
		f.tilt1 = 16'h0633;
		go(f, gn, idl);
		f.tilt1 = 16'h0100;
		f.rxy3 = 16'sh0b1f;
		go(f, gn, idl);
		f.rxy3 = 0;
		f.cn0 = 16'sh0bd7;
		go(f, gn, idl);
		f.cn0 = 0;
		go(f, uv, idl);
		f.cn0 = 16'sh0bd7;
		go(f, uv, idl);
		f.ed = 24'h001e00;
		go(f, uv, idl);
		f.ed = 24'h001e01;
		go(f, gn, idl);
		f.ed = 24'h000100;
		go(f, gn, idl);
	endtask
	// Narrowband unvoiced limits
	task automatic t_nb();
		fr_t f;
		f = quiet(sfmc_pkg::bw_nb);
		f.tilt0 = 16'h09cd;
		go(f, gn, idl);
		f.tilt0 = 16'h0100;
		f.cn2 = 16'sh0ca4;
		go(f, gn, idl);
		f.cn2 = 0;
		f.tilt1 = 16'h0980;
		go(f, gn, idl);
		f.tilt1 = 16'h0100;
		f.ed = 24'h001d00;
		go(f, uv, idl);
		f.ed = 24'h001d01;
		go(f, gn, idl);
		f.ed = 24'h000100;
		go(f, gn, idl);
	endtask
	// Spike, decay, hysteresis and late peak
	task automatic t_spike();
		fr_t f;
		fr_t g;
		g = quiet(sfmc_pkg::bw_wb);
		f = g;
		f.ed = 24'h03e801;
		f.seg[0] = 16'hffff;
		go(f, gn, 3'h0);
		go(g, gn, 3'h1);
		go(g, gn, 3'h2);
		go(g, gn, 3'h2);
		g.det = 16'sh0501;
		go(g, uv, idl);
		g.det = 0;
		f.bw = sfmc_pkg::bw_nb;
		f.rxy3 = 16'sh0ae1;
		go(f, gn, idl);
		f.rxy3 = 0;
		go(f, gn, 3'h0);
		f.bw = sfmc_pkg::bw_wb;
		f.seg[0] = 0;
		f.seg[7] = 16'hffff;
		f.peak_j = 3'h3;
		f.peak_set = 1'b1;
		go(f, gn, 3'h1);
		go(g, gn, 3'h1);
	endtask
	// Stable voiced tests and short-pitch flag
	task automatic t_voiced();
		fr_t v;
		v = quiet(sfmc_pkg::bw_wb);
		v.rxy3 = 16'sh0c00;
		v.cfr = {4{16'h0a00}};
		v.tilt_avg = 16'h0500;
		v.dfr = {16'h0030, 16'h0020, 16'h0010, 16'h0000};
		go(v, vc, idl);
		v.tilt_avg = 16'h0400;
		go(v, gn, idl);
		v.tilt_avg = 16'h0500;
		v.dfr[3] = 16'h0050;
		go(v, gn, idl);
		v.dfr[3] = 16'h0030;
		v.tilt_avg = 16'h0100;
		v.cfr = {4{16'h0ff0}};
		repeat (14) begin
			go(v, ((3 * csm + 'hff0) >>> 2) > 'hf85 ? vc : gn, idl);
		end
		v.cfr = '0;
		v.spitch = 1'b1;
		go(v, vc, idl);
		chk(res.spitch, 1'b1);
		v.spitch = 1'b0;
		v.tol = {4{8'h20}};
		v.voicing_m = 16'sh0f40;
		v.smoothed_voicing = 16'sh0f90;
		go(v, vc, idl);
		chk(res.spitch, 1'b1);
		v = quiet(sfmc_pkg::bw_wb);
		v.spitch = 1'b1;
		go(v, uv, idl);
		chk(res.spitch, 1'b0);
	endtask
	// Main sequence
	initial begin
		rst = 1'b1;
		mismatches = 0;
		cmp_count = 0;
		cycles = 0;
		do_reset();
		t_wb();
		t_nb();
		t_spike();
		do_reset();
		t_voiced();
		test_done();
	end
endmodule
